// file: hdl/qdc_config_regs.sv
// configuration registers and input-path controls of the quad converter
//
// Notes on behaviour
// - quad bit set runs four channels
// - bits seven to four complement channels
// - bit three enables two-apart pointer alarm
// - bit two enables one-apart pointer alarm
// - bit one enables pointer collision alarm
// - input path register resets to 0x7000
// - bit fifteen selects word or byte input
// - bit fourteen: clock loss shuts outputs
// - bit thirteen: data clock loss shuts outputs
// - bit twelve: collision alarm shuts outputs
// - bit seven picks four- or three-wire port
// - bit six enables mixing stage
// - bit five doubles mixer output gain
// - bit four enables oscillator, coarse unaffected
// - bit three reverses input bus order
// - bit one selects twos or offset
// - channel register at 0x01, reset 0x050E
// - proximity code 000,001,01x,1xx
`timescale 1ns/100ps
module qdc_config_regs
(
	input  wire logic        clk_in,              // 250 MHz core clock
	input  wire logic        rst_in,              // async reset, high
	input  wire logic        cfg_wr_in,           // register write strobe
	input  wire logic        cfg_rd_in,           // register read strobe
	input  wire logic [6:0]  cfg_addr_in,         // register address
	input  wire logic [15:0] cfg_wdata_in,        // write data
	output logic      [15:0] cfg_rdata_out,       // read data
	input  wire logic [1:0]  channel_pairing_in,  // pairing field from other register
	input  wire logic        ptr_two_apart_in,    // pointers two apart
	input  wire logic        ptr_one_apart_in,    // pointers one apart
	input  wire logic        ptr_collide_in,      // pointers collided
	input  wire logic        conv_clk_lost_in,    // conversion clock lost
	input  wire logic        data_clk_lost_in,    // input data clock lost
	input  wire logic [15:0] bus_word_in,         // raw input bus word
	input  wire logic [63:0] samples_in,          // four samples, A high
	output logic      [2:0]  prox_alarm_out,      // pointer proximity code
	output logic             outputs_off_out,     // shut off outputs
	output logic      [3:0]  chan_active_out,     // active channels A..D
	output logic             quad_mode_out,       // four-channel mode
	output logic             dual_mode_out,       // dual mode B and C
	output logic      [15:0] bus_word_out,        // bus word after reversal
	output logic             word_wide_input_out, // full-word input
	output logic             four_wire_port_select_out, // four-wire port
	output logic             mixer_on_out,        // mixing stage enable
	output logic             mixer_gain_out,      // extra 6 dB at mixer
	output logic             osc_on_out,          // oscillator enable
	output logic             twos_format_out,     // twos complement samples
	output logic      [63:0] samples_out          // processed samples
);
	logic [15:0] chan_alarm_reg;
	logic [15:0] input_path_reg;
	logic [15:0] chan_alarm_next;
	logic [15:0] input_path_next;

	wire logic sel_chan  = (cfg_addr_in == qdc_pkg::ADDR_CHAN_ALARM);
	wire logic sel_input = (cfg_addr_in == qdc_pkg::ADDR_INPUT_PATH);

	// reserved positions are masked so they can never leave zero
	assign chan_alarm_next = (cfg_wr_in && sel_chan)
		? (cfg_wdata_in & qdc_pkg::WMASK_CHAN_ALARM) : chan_alarm_reg;
	assign input_path_next = (cfg_wr_in && sel_input)
		? (cfg_wdata_in & qdc_pkg::WMASK_INPUT_PATH) : input_path_reg;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			chan_alarm_reg <= qdc_pkg::RST_CHAN_ALARM;
			input_path_reg <= qdc_pkg::RST_INPUT_PATH;
		end
		else
		begin
			chan_alarm_reg <= chan_alarm_next;
			input_path_reg <= input_path_next;
		end
	end

	wire logic [15:0] rd_mux = sel_chan ? chan_alarm_reg
		: (sel_input ? input_path_reg : 16'h0000);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			cfg_rdata_out <= 16'h0000;
		else if (cfg_rd_in)
			cfg_rdata_out <= rd_mux;
	end

	// channel mode
	wire logic quad_bit = chan_alarm_reg[qdc_pkg::BIT_QUAD];
	wire logic dual_ok  = !quad_bit && (channel_pairing_in == qdc_pkg::PAIR_DUAL);
	assign quad_mode_out   = quad_bit;
	assign dual_mode_out   = dual_ok;
	assign chan_active_out = quad_bit ? 4'hF : (dual_ok ? 4'h6 : 4'h0);

	// pointer proximity, each class gated by its enable
	wire logic two_en = chan_alarm_reg[qdc_pkg::BIT_TWO_APART] & ptr_two_apart_in;
	wire logic one_en = chan_alarm_reg[qdc_pkg::BIT_ONE_APART] & ptr_one_apart_in;
	wire logic col_en = chan_alarm_reg[qdc_pkg::BIT_COLLIDE] & ptr_collide_in;
	wire logic [2:0] prox_next = col_en ? qdc_pkg::PROX_COLLIDE
		: (one_en ? qdc_pkg::PROX_ONE_APART
		: (two_en ? qdc_pkg::PROX_TWO_APART : qdc_pkg::PROX_NORMAL));

	// shutdown sources, taken from the enabled inputs, not the registered alarm
	wire logic off_next =
		(input_path_reg[qdc_pkg::BIT_CLK_SHUT] & conv_clk_lost_in)
		| (input_path_reg[qdc_pkg::BIT_DCLK_SHUT] & data_clk_lost_in)
		| (input_path_reg[qdc_pkg::BIT_COLL_SHUT] & col_en);

	// bus reversal: msb becomes lsb
	logic [15:0] rev_word;
	always_comb
	begin
		for (int i = 0; i < 16; i++)
			rev_word[i] = bus_word_in[15 - i];
	end
	wire logic [15:0] bus_next = input_path_reg[qdc_pkg::BIT_REVERSE]
		? rev_word : bus_word_in;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prox_alarm_out  <= qdc_pkg::PROX_NORMAL;
			outputs_off_out <= 1'b0;
			bus_word_out    <= 16'h0000;
		end
		else
		begin
			prox_alarm_out  <= prox_next;
			outputs_off_out <= off_next;
			bus_word_out    <= bus_next;
		end
	end

	assign word_wide_input_out       = input_path_reg[qdc_pkg::BIT_WORD_WIDE];
	assign four_wire_port_select_out = input_path_reg[qdc_pkg::BIT_FOUR_WIRE];
	assign mixer_on_out              = input_path_reg[qdc_pkg::BIT_MIX_ON];
	// gain only matters while mixing runs
	assign mixer_gain_out = input_path_reg[qdc_pkg::BIT_MIX_GAIN]
		& input_path_reg[qdc_pkg::BIT_MIX_ON];
	// coarse mixing needs only mixer_on, not the oscillator
	assign osc_on_out      = input_path_reg[qdc_pkg::BIT_OSC_ON];
	assign twos_format_out = input_path_reg[qdc_pkg::BIT_TWOS];

	// channel A sits in the top slice; invert bit order runs A..D downward
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_chan
			qdc_chan_invert u_inv
			(
				.clk_in    (clk_in),
				.rst_in    (rst_in),
				.invert_in (chan_alarm_reg[qdc_pkg::BIT_INV_D + g]),
				.active_in (chan_active_out[g]),
				.sample_in (samples_in[16*g +: 16]),
				.sample_out(samples_out[16*g +: 16])
			);
		end
	endgenerate
endmodule

// file: inc/qdc_pkg.sv
// package for the quad converter datapath configuration registers
package qdc_pkg;
	localparam logic [6:0]  ADDR_CHAN_ALARM   = 7'h01;
	localparam logic [6:0]  ADDR_INPUT_PATH   = 7'h02;
	localparam logic [15:0] RST_CHAN_ALARM    = 16'h050E;
	localparam logic [15:0] RST_INPUT_PATH    = 16'h7000;
	// writable field masks; reserved positions stay zero
	localparam logic [15:0] WMASK_CHAN_ALARM  = 16'hB7FE;
	localparam logic [15:0] WMASK_INPUT_PATH  = 16'hF0FA;
	// channel and alarm control fields
	localparam int          BIT_QUAD          = 8;
	localparam int          BIT_INV_A         = 7;
	localparam int          BIT_INV_D         = 4;
	localparam int          BIT_TWO_APART     = 3;
	localparam int          BIT_ONE_APART     = 2;
	localparam int          BIT_COLLIDE       = 1;
	// input path control fields
	localparam int          BIT_WORD_WIDE     = 15;
	localparam int          BIT_CLK_SHUT      = 14;
	localparam int          BIT_DCLK_SHUT     = 13;
	localparam int          BIT_COLL_SHUT     = 12;
	localparam int          BIT_FOUR_WIRE     = 7;
	localparam int          BIT_MIX_ON        = 6;
	localparam int          BIT_MIX_GAIN      = 5;
	localparam int          BIT_OSC_ON        = 4;
	localparam int          BIT_REVERSE       = 3;
	localparam int          BIT_TWOS          = 1;
	// pointer proximity codes
	localparam logic [2:0]  PROX_NORMAL       = 3'h0;
	localparam logic [2:0]  PROX_TWO_APART    = 3'h1;
	localparam logic [2:0]  PROX_ONE_APART    = 3'h2;
	localparam logic [2:0]  PROX_COLLIDE      = 3'h4;
	localparam logic [1:0]  PAIR_DUAL         = 2'h3;
endpackage

// file: hdl/qdc_chan_invert.sv
// per-channel sample inversion stage
`timescale 1ns/100ps
module qdc_chan_invert
(
	input  wire logic        clk_in,     // core clock
	input  wire logic        rst_in,     // async reset, high
	input  wire logic        invert_in,  // complement this channel
	input  wire logic        active_in,  // channel in use
	input  wire logic [15:0] sample_in,  // sample word
	output logic      [15:0] sample_out  // registered result
);
	wire logic [15:0] inv_word = invert_in ? ~sample_in : sample_in;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			sample_out <= 16'h0000;
		else
			sample_out <= active_in ? inv_word : 16'h0000;
	end
endmodule

// file: sim/qdc_chk.sv
// port assertions for the configuration registers
`timescale 1ns/100ps
module qdc_chk
(
	input wire logic        clk_in,           // core clock
	input wire logic        rst_in,           // async reset, high
	input wire logic        cfg_rd_in,        // read strobe
	input wire logic        ptr_two_apart_in, // pointers two apart
	input wire logic        ptr_one_apart_in, // pointers one apart
	input wire logic        ptr_collide_in,   // pointers collided
	input wire logic        conv_clk_lost_in, // conversion clock lost
	input wire logic        data_clk_lost_in, // data clock lost
	input wire logic        outputs_off_out,  // shutdown level
	input wire logic        quad_mode_out,    // four-channel mode
	input wire logic        dual_mode_out,    // dual mode
	input wire logic        mixer_on_out,     // mixer enable
	input wire logic        mixer_gain_out,   // mixer gain
	input wire logic [6:0]  cfg_addr_in,      // register address
	input wire logic [15:0] cfg_rdata_out,    // read data
	input wire logic [15:0] bus_word_in,      // raw bus word
	input wire logic [15:0] bus_word_out,     // bus word after reversal
	input wire logic [2:0]  prox_alarm_out,   // proximity code
	input wire logic [3:0]  chan_active_out   // active channels
);
	logic      [15:0] bw_prev;
	wire logic [15:0] bw_rev = {<<{bw_prev}};
	wire logic        lost = conv_clk_lost_in | data_clk_lost_in | ptr_collide_in;
	always_ff @(posedge clk_in) bw_prev <= bus_word_in;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	rd_unmapped_a: assert property (cfg_rd_in && !(cfg_addr_in inside {7'h01, 7'h02})
		|=> cfg_rdata_out == 16'h0000) else $error("unmapped read not zero");
	prox_code_a: assert property ($onehot0(prox_alarm_out)) else $error("bad prox code");
	collide_src_a: assert property (prox_alarm_out[2] |-> $past(ptr_collide_in))
		else $error("collide code without cause");
	one_src_a: assert property (prox_alarm_out[1] |-> $past(ptr_one_apart_in))
		else $error("one-apart code without cause");
	prox_quiet_a: assert property (!(ptr_two_apart_in | ptr_one_apart_in | ptr_collide_in)
		|=> prox_alarm_out == 3'h0) else $error("prox code while quiet");
	off_quiet_a: assert property (!lost |=> !outputs_off_out) else $error("shutdown w/o cause");
	chan_map_a: assert property (chan_active_out == (quad_mode_out ? 4'hF :
		dual_mode_out ? 4'h6 : 4'h0)) else $error("channel map wrong");
	gain_mix_a: assert property (mixer_gain_out |-> mixer_on_out) else $error("gain w/o mixer");
	bus_rev_a: assert property (!$past(rst_in) |-> bus_word_out == bw_prev ||
		bus_word_out == bw_rev) else $error("bus word neither straight nor reversed");
	cover property (prox_alarm_out == 3'h4);
	cover property (outputs_off_out);
	cover property (dual_mode_out);
endmodule
bind qdc_config_regs qdc_chk u_chk (.*);

// file: sim/qdc_host.sv
// host model driving the register strobes
`timescale 1ns/100ps
module qdc_host
(
	input  wire logic        clk_in,    // core clock
	input  wire logic [15:0] rdata_in,  // read data
	output logic             wr_out,    // write strobe
	output logic             rd_out,    // read strobe
	output logic      [6:0]  addr_out,  // register address
	output logic      [15:0] wdata_out  // write data
);
	initial {wr_out, rd_out, addr_out, wdata_out} = '0;
	// any value goes out, reserved bits included, so refusal is seen
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk_in);
		{wr_out, addr_out, wdata_out} <= {1'b1, a, d};
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [15:0] v);
		@(posedge clk_in);
		{rd_out, addr_out} <= {1'b1, a};
		@(posedge clk_in);
		rd_out <= 1'b0;
		// registered data stands from the strobe edge until the next read
		@(posedge clk_in);
		v = rdata_in;
	endtask
endmodule

// file: sim/qdc_config_regs_tb.sv
// self-checking bench for the configuration registers
`timescale 1ns/100ps
module qdc_config_regs_tb;
	logic clk_in = 0, rst_in = 1, cfg_wr_in, cfg_rd_in, ptr_two_apart_in = 0, ptr_one_apart_in = 0;
	logic ptr_collide_in = 0, conv_clk_lost_in = 0, data_clk_lost_in = 0, outputs_off_out;
	logic quad_mode_out, dual_mode_out, word_wide_input_out, four_wire_port_select_out;
	logic mixer_on_out, mixer_gain_out, osc_on_out, twos_format_out;
	logic [1:0] channel_pairing_in = 0;
	logic [2:0] prox_alarm_out;
	logic [3:0] chan_active_out, act;
	logic [6:0] cfg_addr_in, a;
	logic [15:0] cfg_wdata_in, cfg_rdata_out, bus_word_in = 0, bus_word_out, r1, r2, d, v;
	logic [63:0] samples_in = 0, samples_out, s;
	int n_errors = 0, comparisons = 0;
	always #2 clk_in = ~clk_in;
	qdc_config_regs DUT (.*);
	qdc_host u_host (.clk_in(clk_in), .rdata_in(cfg_rdata_out), .wr_out(cfg_wr_in),
		.rd_out(cfg_rd_in), .addr_out(cfg_addr_in), .wdata_out(cfg_wdata_in));
	task automatic chk(input string nm, input logic [63:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_errors++;
		report_and_stop;
	end
	initial
	begin
		void'($urandom(77));
		{r1, r2} = {16'h050E, 16'h7000};
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 60; i++)
		begin
			// pass 30 resets mid-run; passes 0 and 30 write nowhere so reset values read back
			if (i == 30)
			begin
				@(posedge clk_in);
				rst_in <= 1'b1;
				repeat (2) @(posedge clk_in);
				rst_in <= 1'b0;
				{r1, r2} = {qdc_pkg::RST_CHAN_ALARM, qdc_pkg::RST_INPUT_PATH};
			end
			{a, d} = {7'($urandom_range(3)), 16'($urandom)};
			if (i % 30 == 0)
				a = 7'h00;
			u_host.wr(a, d);
			if (a == 7'h01)
				r1 = d & qdc_pkg::WMASK_CHAN_ALARM;
			if (a == 7'h02)
				r2 = d & qdc_pkg::WMASK_INPUT_PATH;
			u_host.rd(7'h01, v);
			chk("chan_alarm", r1, v);
			u_host.rd(7'h02, v);
			chk("input_path", r2, v);
			u_host.rd(7'h03, v);
			chk("unmapped", 0, v);
			@(posedge clk_in);
			{ptr_two_apart_in, ptr_one_apart_in, ptr_collide_in, conv_clk_lost_in,
				data_clk_lost_in, channel_pairing_in} <= 7'($urandom);
			{bus_word_in, samples_in} <= {16'($urandom), $urandom, $urandom};
			@(posedge clk_in);
			#1 act = r1[8] ? 4'hF : (channel_pairing_in == 2'h3 ? 4'h6 : 4'h0);
			for (int k = 0; k < 4; k++)
				s[63-16*k -: 16] = act[3-k] ? samples_in[63-16*k -: 16] ^ {16{r1[7-k]}} : 16'h0;
			v = {<<{bus_word_in}};
			chk("active", act, chan_active_out);
			chk("mode", {r1[8], act == 4'h6}, {quad_mode_out, dual_mode_out});
			chk("samples", s, samples_out);
			chk("prox", ptr_collide_in & r1[1] ? 4 : ptr_one_apart_in & r1[2] ? 2 :
				ptr_two_apart_in & r1[3] ? 1 : 0, prox_alarm_out);
			chk("off", r2[14] & conv_clk_lost_in | r2[13] & data_clk_lost_in |
				r2[12] & ptr_collide_in & r1[1], outputs_off_out);
			chk("bus", r2[3] ? v : bus_word_in, bus_word_out);
			chk("levels", {r2[15], r2[7], r2[6], r2[5] & r2[6], r2[4], r2[1]},
				{word_wide_input_out, four_wire_port_select_out, mixer_on_out, mixer_gain_out,
				osc_on_out, twos_format_out});
		end
		report_and_stop;
	end
endmodule
